/* nvsc_defines.vh */
// constants for the nonvolatile special command and pause block
`ifndef NVSC_DEFINES_VH
`define NVSC_DEFINES_VH
`define NVSC_OP_SAVE 8'h3c
`define NVSC_OP_RECALL 8'h60
`define NVSC_OP_AS_EN 8'h59
`define NVSC_OP_AS_DIS 8'h19
`define NVSC_OP_WREN 8'h06
`define NVSC_OP_WRDI 8'h04
`define NVSC_OP_READ 8'h03
`define NVSC_OP_WRITE 8'h02
`define NVSC_CLK_MHZ 10
`define NVSC_TSEQ_US 500
`define NVSC_TSEQ_CYC (`NVSC_TSEQ_US * `NVSC_CLK_MHZ)
`define NVSC_TSAVE_US 8000
`define NVSC_TSAVE_CYC (`NVSC_TSAVE_US * `NVSC_CLK_MHZ)
`define NVSC_TRECALL_US 200
`define NVSC_TRECALL_CYC (`NVSC_TRECALL_US * `NVSC_CLK_MHZ)
`define NVSC_CNT_W 20
`endif

/* nvsc_sync.v */
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
module nvsc_sync #(
	parameter RST_VAL = 1'b0
) (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// level
	input wire d,
	output reg q
);
	reg meta_q;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule // nvsc_sync

/* nvsc_core.v */
// special command decoder, write latch, busy timer and pause handling
`timescale 1ns/100ps
`include "nvsc_defines.vh"
// Summary of operation
// RULE_01: opcodes 3c save, 60 recall, 59 enable power-loss save.
// RULE_02: opcode 19 disables the power-loss save.
// RULE_03: save always copies the array, written or not.
// RULE_04: special commands act only with the write latch set.
// RULE_05: host sends one opcode byte right after select falls.
// RULE_06: write latch clears at the select rise ending a special command.
// RULE_07: recall restores the array from the nonvolatile cells.
// RULE_08: enable opcode turns on the power-loss save.
// RULE_09: power-loss save setting is volatile; a save makes it persist. Here reset always reloads HAS_PLS, whatever was saved.
// RULE_10: variants with power-loss save start with it enabled.
// RULE_11: variant without it ignores enable/disable but still reports busy.
// RULE_12: pause low while selected freezes the sequence without reset.
// RULE_13: host lowers pause only while the serial clock is low.
// RULE_14: host keeps select low throughout a pause.
// RULE_15: while paused, input ignored, output released, clock edges ignored.
// RULE_16: host raises pause only while the serial clock is low.
// RULE_17: without the latch, write commands are ignored until next select.
// RULE_18: busy shows in ready bit; array commands refused meanwhile.
// RULE_19: busy from the ending select rise until the operation completes.
module nvsc_core #(
	parameter HAS_PLS = 1'b1,
	parameter [19:0] TSEQ_CYC = `NVSC_TSEQ_CYC,
	parameter [19:0] TSAVE_CYC = `NVSC_TSAVE_CYC,
	parameter [19:0] TRECALL_CYC = `NVSC_TRECALL_CYC
) (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// serial pins
	input wire cs_n,
	input wire sck,
	input wire si,
	input wire pause_n,
	input wire so_data,
	output wire so_oe,
	// write latch joined with the status logic
	input wire wel_set,
	input wire wel_clr_ext,
	output reg wel_q,
	// array side
	output reg save_start_q,
	output reg recall_start_q,
	input wire nv_done,
	output reg busy_q,
	output wire array_cmd_ok,
	// power-loss save
	output reg power_loss_save_q,
	// decoded opcode of current frame
	output reg [7:0] opcode_q,
	output reg opcode_valid_q
);
	localparam [1:0] ST_IDLE = 2'd0;
	localparam [1:0] ST_TIMED = 2'd1;
	localparam [1:0] ST_WAIT = 2'd2;
	wire cs_s, sck_s, si_s, pause_s;
	reg sck_prev_q, cs_prev_q;
	reg [2:0] bit_cnt_q;
	reg [7:0] shift_q;
	reg [1:0] state_q;
	reg [19:0] cnt_q;
	reg paused_q;
	wire sel, sck_rise, cs_rise, frame_start;
	nvsc_sync #(.RST_VAL(1'b1)) u_cs (.clk(clk), .rst_n(rst_n),
		.d(cs_n), .q(cs_s));
	nvsc_sync #(.RST_VAL(1'b0)) u_sck (.clk(clk), .rst_n(rst_n),
		.d(sck), .q(sck_s));
	nvsc_sync #(.RST_VAL(1'b0)) u_si (.clk(clk), .rst_n(rst_n),
		.d(si), .q(si_s));
	nvsc_sync #(.RST_VAL(1'b1)) u_hold (.clk(clk), .rst_n(rst_n),
		.d(pause_n), .q(pause_s));
	assign sel = ~cs_s;
	assign frame_start = cs_prev_q & ~cs_s;
	assign cs_rise = ~cs_prev_q & cs_s;
	// pause is only sampled while sck low, which the host guarantees
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			paused_q <= 1'b0;
		end else if (!sel) begin
			paused_q <= 1'b0;
		end else if (!sck_s) begin
			paused_q <= ~pause_s; // RULE_12 RULE_13 RULE_16
		end
	end
	assign sck_rise = sck_s & ~sck_prev_q & sel & ~paused_q; // RULE_15
	assign so_oe = sel & ~paused_q & opcode_valid_q &
		(opcode_q == `NVSC_OP_READ) & array_cmd_ok; // RULE_15
	wire so_unused = so_data;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sck_prev_q <= 1'b0;
			cs_prev_q <= 1'b1;
		end else begin
			sck_prev_q <= sck_s;
			cs_prev_q <= cs_s;
		end
	end
	// opcode capture: first eight bits after select falls
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt_q <= 3'h0;
			shift_q <= 8'h00;
			opcode_q <= 8'h00;
			opcode_valid_q <= 1'b0;
		end else if (frame_start || !sel) begin
			bit_cnt_q <= 3'h0;
			opcode_valid_q <= 1'b0;
		end else if (sck_rise && !opcode_valid_q) begin
			shift_q <= {shift_q[6:0], si_s}; // RULE_05
			bit_cnt_q <= bit_cnt_q + 3'h1;
			if (bit_cnt_q == 3'h7) begin
				opcode_q <= {shift_q[6:0], si_s};
				opcode_valid_q <= 1'b1;
			end
		end
	end
	wire is_save = opcode_q == `NVSC_OP_SAVE; // RULE_01
	wire is_recall = opcode_q == `NVSC_OP_RECALL; // RULE_01
	wire is_as_en = opcode_q == `NVSC_OP_AS_EN; // RULE_01
	wire is_as_dis = opcode_q == `NVSC_OP_AS_DIS; // RULE_02
	wire is_special = is_save | is_recall | is_as_en | is_as_dis;
	// frame ends: only a complete opcode with the latch set is acted on
	wire act = cs_rise & opcode_valid_q & is_special & wel_q &
		~busy_q; // RULE_04 RULE_17
	// write latch: the status logic sets it, special commands clear it
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wel_q <= 1'b0;
		end else if (wel_set) begin
			wel_q <= 1'b1;
		end else if (act || wel_clr_ext) begin
			wel_q <= 1'b0; // RULE_06
		end
	end
	// power-loss save flag is volatile, so it returns to default on reset
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			power_loss_save_q <= HAS_PLS; // RULE_09 RULE_10
		end else if (act && HAS_PLS) begin
			if (is_as_en) begin
				power_loss_save_q <= 1'b1; // RULE_08
			end else if (is_as_dis) begin
				power_loss_save_q <= 1'b0; // RULE_02
			end
		end
	end
	// busy sequencer
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			cnt_q <= 20'h0;
			busy_q <= 1'b0;
			save_start_q <= 1'b0;
			recall_start_q <= 1'b0;
		end else begin
			save_start_q <= 1'b0;
			recall_start_q <= 1'b0;
			case (state_q)
			ST_IDLE: begin
				if (act) begin
					busy_q <= 1'b1; // RULE_19 RULE_18
					if (is_save) begin
						save_start_q <= 1'b1; // RULE_03
						cnt_q <= TSAVE_CYC;
						state_q <= ST_WAIT;
					end else if (is_recall) begin
						recall_start_q <= 1'b1; // RULE_07
						cnt_q <= TRECALL_CYC;
						state_q <= ST_WAIT;
					end else begin
						cnt_q <= TSEQ_CYC; // RULE_11
						state_q <= ST_TIMED;
					end
				end
			end
			ST_TIMED: begin
				if (cnt_q <= 20'h1) begin
					busy_q <= 1'b0; // RULE_19
					state_q <= ST_IDLE;
				end else begin
					cnt_q <= cnt_q - 20'h1;
				end
			end
			ST_WAIT: begin
				// array reports done; the counter is a backstop only
				if (nv_done || cnt_q <= 20'h1) begin
					busy_q <= 1'b0; // RULE_19
					state_q <= ST_IDLE;
				end else begin
					cnt_q <= cnt_q - 20'h1;
				end
			end
			default: begin
				state_q <= ST_IDLE;
				busy_q <= 1'b0;
			end
			endcase
		end
	end
	assign array_cmd_ok = ~busy_q; // RULE_18
endmodule // nvsc_core

/* nvsc_core_sva.sv */
// port assertions for the special command block
`timescale 1ns/100ps
module nvsc_core_sva (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// watched pins
	input wire pause_n,
	input wire so_oe,
	input wire wel_q,
	input wire save_start_q,
	input wire recall_start_q,
	input wire busy_q,
	input wire array_cmd_ok,
	input wire power_loss_save_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_ok_busy: assert property (array_cmd_ok == !busy_q)
		else $error("array ok while busy");
	a_save_pulse: assert property (save_start_q |=> !save_start_q)
		else $error("save pulse too long");
	a_start_latch: assert property ($rose(busy_q) |-> $past(wel_q))
		else $error("busy without latch");
	a_wel_clear: assert property ($rose(busy_q) |-> !wel_q)
		else $error("latch not cleared");
	a_busy_oe: assert property (busy_q |-> !so_oe)
		else $error("output on while busy");
	// four cycles cover the pause synchroniser and the pause flop
	a_pause_oe: assert property (!pause_n [*4] |-> !so_oe)
		else $error("output on while paused");
	a_pls_busy: assert property ($changed(power_loss_save_q) |-> busy_q)
		else $error("save enable moved idle");
	a_start_busy: assert property (save_start_q || recall_start_q |-> busy_q)
		else $error("start without busy");
	c_save: cover property (save_start_q);
	c_recall: cover property (recall_start_q);
	c_pls_off: cover property ($fell(power_loss_save_q));
endmodule // nvsc_core_sva

/* nvsc_host.sv */
// serial host model driving select, clock, data and pause
`timescale 1ns/100ps
module nvsc_host (
	input wire clk,
	output reg cs_n,
	output reg sck,
	output reg si,
	output reg pause_n
);
	initial begin
		cs_n = 1;
		sck = 0;
		si = 0;
		pause_n = 1;
	end
	// half of an 800 ns link clock period
	task automatic half;
		repeat (4) @(posedge clk);
	endtask
	task automatic send(input [7:0] b, input bit h);
		integer i;
		cs_n <= 0;
		half();
		for (i = 7; i >= 0; i--) begin
			si <= b[i];
			half();
			sck <= 1;
			half();
			sck <= 0;
			if (h && i == 4) begin
				pause_n <= 0;
				half();
				repeat (2) begin
					si <= ~si;
					sck <= 1;
					half();
					sck <= 0;
					half();
				end
				pause_n <= 1;
				half();
			end
		end
		half();
		cs_n <= 1;
		si <= ~b[0];
	endtask
endmodule // nvsc_host

/* nvsc_core_test.sv */
// self-checking bench for the special command block
`timescale 1ns/100ps
module nvsc_core_test;
	reg clk, rst_n, wel_set, nv_done;
	wire cs_n, sck, si, pause_n, so_oe, wel_q, save_start_q;
	wire recall_start_q, busy_q, array_cmd_ok, power_loss_save_q;
	integer err_total = 0, compares = 0, i;
	reg [11:0] rows [0:5];
	nvsc_host host_u (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si),
		.pause_n(pause_n));
	nvsc_core #(.TSEQ_CYC(20'd20), .TSAVE_CYC(20'd60),
		.TRECALL_CYC(20'd60)) dut_u (.clk(clk), .rst_n(rst_n),
		.cs_n(cs_n), .sck(sck), .si(si), .pause_n(pause_n),
		.so_data(1'b0), .so_oe(so_oe), .wel_set(wel_set),
		.wel_clr_ext(1'b0), .wel_q(wel_q), .save_start_q(save_start_q),
		.recall_start_q(recall_start_q), .nv_done(nv_done),
		.busy_q(busy_q), .array_cmd_ok(array_cmd_ok),
		.power_loss_save_q(power_loss_save_q), .opcode_q(),
		.opcode_valid_q());
	task automatic chk(input bit ok, input string m);
		compares++;
		if (!ok) begin
			err_total++;
			$display("wrong value %0t %s", $time, m);
		end
	endtask
	task results;
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic run(input [7:0] op, input bit w, h, s, r, p);
		integer n, nb;
		bit gs, gr, go;
		gs = 0;
		gr = 0;
		go = 0;
		nb = 0;
		@(posedge clk);
		wel_set <= w;
		@(posedge clk);
		wel_set <= 0;
		host_u.send(op, h);
		for (n = 0; n < 200 && (n < 12 || busy_q); n++) begin
			@(posedge clk) nv_done <= (n == 15);
			@(negedge clk) gs |= save_start_q;
			gr |= recall_start_q;
			go |= so_oe;
			nb += busy_q;
		end
		chk(gs === s && gr === r, "start");
		chk((nb > 0) === w, "busy seen");
		chk(!w || s || r || nb == 20, "busy time");
		chk(go === 1'b0, "output enabled");
		chk(wel_q === 1'b0, "latch");
		chk(power_loss_save_q === p, "save enable");
	endtask
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	initial begin
		#2000000;
		err_total++;
		results();
	end
	initial begin
		rows[0] = {8'h3c, 4'b1101};
		rows[1] = {8'h60, 4'b1011};
		rows[2] = {8'h19, 4'b1000};
		rows[3] = {8'h3c, 4'b0000};
		rows[4] = {8'h59, 4'b1001};
		rows[5] = {8'h19, 4'b0001};
		rst_n = 0;
		wel_set = 0;
		nv_done = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1;
		@(negedge clk);
		chk(power_loss_save_q === 1'b1 && wel_q === 1'b0, "reset");
		for (i = 0; i < 6; i++)
			run(rows[i][11:4], rows[i][3], 0, rows[i][2], rows[i][1],
				rows[i][0]);
		// clocks inside the pause must not shift in
		run(8'h60, 1, 1, 0, 1, 1);
		// reset in mid-operation must restore the volatile default
		@(posedge clk);
		wel_set <= 1;
		@(posedge clk);
		wel_set <= 0;
		host_u.send(8'h19, 0);
		repeat (8) @(posedge clk);
		@(negedge clk);
		chk(busy_q === 1'b1 && power_loss_save_q === 1'b0, "off");
		@(posedge clk);
		rst_n <= 0;
		repeat (2) @(posedge clk);
		rst_n <= 1;
		@(negedge clk);
		chk(busy_q === 1'b0 && wel_q === 1'b0 &&
			power_loss_save_q === 1'b1, "reset again");
		results();
	end
endmodule // nvsc_core_test
bind nvsc_core nvsc_core_sva chk_u (.clk(clk), .rst_n(rst_n),
	.pause_n(pause_n), .so_oe(so_oe), .wel_q(wel_q),
	.save_start_q(save_start_q), .recall_start_q(recall_start_q),
	.busy_q(busy_q), .array_cmd_ok(array_cmd_ok),
	.power_loss_save_q(power_loss_save_q));
